// ===== src/rcb_ctrl.v
// Reset gathering, clock-source control, clock-fail monitor and boot latch.
// Function
// RULE_01: System reset restores all but causes, backup.
// RULE_02: Five sources each raise system reset.
// RULE_03: Distinct cause flag per reset source.
// RULE_04: System clock selects one of three sources.
// RULE_05: Slow internal osc clocks watchdog, optional RTC.
// RULE_06: Slow external osc selectable as RTC clock.
// RULE_07: Each source has independent on/off control.
// RULE_08: Bypass mode tristates fast output pin.
// RULE_09: Clock-fail monitor enabled only by software.
// RULE_10: Monitor starts after startup, stops with oscillator.
// RULE_11: Detected failure switches external oscillator off.
// RULE_12: Failure drives advanced timer break input.
// RULE_13: Failure raises interrupt routed to NMI.
// RULE_14: Failing clock in use: switch to internal.
// RULE_15: Failing clock feeding system PLL: disable PLL.
// RULE_16: Boot space decoded from two boot pins.
// RULE_17: Boot pins latched on fourth edge after reset.
// RULE_18: Board drives boot pins valid after reset.
// RULE_19: Boot pins resampled on leaving standby.
// RULE_20: Processor starts at stack 0, vector 4.
// RULE_21: Held in reset while supply is low.
// RULE_22: Reset pin synchronised, reset held one cycle; code holds it two cycles after the source drops.
// RULE_23: Cause flags persist until software clears.
`include "rcb_map.vh"
module rcb_ctrl (
    input wire clk_sys_in, // System clock, 10 MHz.
    input wire rst_n_in, // Power-on reset, active low, synchronous.
    input wire supply_ok_in, // Main supply above power-on threshold.
    input wire ext_reset_pin_n_in, // External reset pin, active low.
    input wire window_watchdog_in, // Window watchdog end of count.
    input wire independent_watchdog_in, // Independent watchdog end of count.
    input wire sw_reset_req_in, // Software reset request.
    input wire lp_reset_req_in, // Low-power management reset request.
    input wire clear_causes_in, // Software clears reset-cause flags.
    input wire fast_int_on_in, // Fast internal oscillator enable.
    input wire fast_ext_on_in, // Fast external oscillator enable.
    input wire fast_ext_bypass_in, // Fast external bypass mode.
    input wire pll_on_in, // PLL enable.
    input wire pll_from_ext_in, // PLL input is fast external oscillator.
    input wire slow_int_on_in, // Slow internal oscillator enable.
    input wire slow_ext_on_in, // Slow external oscillator enable.
    input wire [1:0] system_clock_sel_in, // Requested system clock source.
    input wire [1:0] rtc_sel_in, // Requested RTC clock source.
    input wire monitor_en_in, // Clock-fail monitor enable.
    input wire fast_ext_tick_in, // Fast external clock activity, async.
    input wire standby_exit_in, // Pulse when leaving standby.
    input wire boot_select_0_in, // Boot pin 0.
    input wire boot_select_1_in, // Boot pin 1.
    output reg sys_reset_n_out, // System reset to the core, active low.
    output reg [5:0] clock_ctrl_status_reg_out, // Reset-cause flags.
    output reg fast_int_en_out, // Fast internal oscillator run.
    output reg fast_ext_en_out, // Fast external oscillator run.
    output reg pll_en_out, // PLL run.
    output reg slow_int_en_out, // Slow internal oscillator run.
    output reg slow_ext_en_out, // Slow external oscillator run.
    output reg [1:0] system_clock_sel_out, // Active system clock source.
    output reg [1:0] rtc_clock_sel_out, // Active RTC clock source.
    output reg fast_pin_b_oe_out, // Fast oscillator output pin drive.
    output reg monitor_active_out, // Detector running.
    output reg advanced_timer_break_out, // Failure event to timer break.
    output reg clock_fail_irq_out, // Clock-fail NMI request, sticky.
    output reg [1:0] boot_space_out, // Latched boot space.
    output reg boot_done_out, // Boot pins latched, fetch may start.
    output wire [31:0] stack_addr_out, // Initial stack pointer address.
    output wire [31:0] reset_vec_addr_out // First fetch address.
);
    reg pin_s1_q, pin_s2_q, tick_s1_q, tick_s2_q, tick_s3_q;
    reg boot_select_0_s1_q, boot_select_0_s2_q, boot_select_1_s1_q, boot_select_1_s2_q;
    reg [1:0] hold_q;
    reg [2:0] boot_cnt_q;
    reg [7:0] start_cnt_q;
    reg [7:0] idle_cnt_q;
    reg ext_kill_q;
    reg pll_kill_q;
    reg use_int_q;
    wire [4:0] src;
    wire any_src;
    wire sys_rst;
    wire fail;
    wire ext_in_use;
    wire boot_pulse;

    // Synchronised reset pin, both watchdogs, software and low-power requests are the five sources here.
    assign src = {lp_reset_req_in, sw_reset_req_in, independent_watchdog_in,
                  window_watchdog_in, ~pin_s2_q}; // RULE_02
    assign any_src = |src;
    assign sys_rst = ~rst_n_in | ~supply_ok_in | any_src | (hold_q != 2'h0); // RULE_21
    assign stack_addr_out = `RCB_STACK_ADDR; // RULE_20
    assign reset_vec_addr_out = `RCB_RESET_VEC_ADDR; // RULE_20
    assign ext_in_use = (system_clock_sel_out == `RCB_SRC_FAST_EXT) |
                        ((system_clock_sel_out == `RCB_SRC_PLL) & pll_from_ext_in);
    assign fail = monitor_active_out & (idle_cnt_q == `RCB_FAIL_TIMEOUT);
    assign boot_pulse = (boot_cnt_q == `RCB_BOOT_EDGE - 3'h1);

    always @(posedge clk_sys_in) begin
        pin_s1_q <= ext_reset_pin_n_in; // RULE_22
        pin_s2_q <= pin_s1_q;
        tick_s1_q <= fast_ext_tick_in;
        tick_s2_q <= tick_s1_q;
        tick_s3_q <= tick_s2_q;
        boot_select_0_s1_q <= boot_select_0_in;
        boot_select_0_s2_q <= boot_select_0_s1_q;
        boot_select_1_s1_q <= boot_select_1_in;
        boot_select_1_s2_q <= boot_select_1_s1_q;
    end

    // Reset stretch and cause flags; causes survive system reset.
    always @(posedge clk_sys_in) begin
        if (!rst_n_in || !supply_ok_in) begin
            hold_q <= `RCB_RST_HOLD;
            clock_ctrl_status_reg_out <= `RCB_CAUSE_RST;
            sys_reset_n_out <= 1'b0;
        end else begin
            if (any_src) begin
                hold_q <= `RCB_RST_HOLD; // RULE_22
            end else if (hold_q != 2'h0) begin
                hold_q <= hold_q - 2'h1;
            end
            sys_reset_n_out <= ~sys_rst;
            // Set wins over a coincident clear.
            clock_ctrl_status_reg_out <= (clear_causes_in ? 6'h00 : clock_ctrl_status_reg_out)
                                         | {1'b0, src}; // RULE_03 RULE_23
        end
    end

    // Clock control under system reset, which spares the cause flags.
    always @(posedge clk_sys_in) begin
        if (sys_rst) begin // RULE_01
            ext_kill_q <= 1'b0;
            pll_kill_q <= 1'b0;
            use_int_q <= 1'b0;
            start_cnt_q <= 8'h00;
            idle_cnt_q <= 8'h00;
            monitor_active_out <= 1'b0;
            advanced_timer_break_out <= 1'b0;
            clock_fail_irq_out <= 1'b0;
            fast_int_en_out <= 1'b1;
            fast_ext_en_out <= 1'b0;
            pll_en_out <= 1'b0;
            slow_int_en_out <= 1'b0;
            slow_ext_en_out <= 1'b0;
            system_clock_sel_out <= `RCB_SRC_FAST_INT;
            rtc_clock_sel_out <= `RCB_RTC_NONE;
            fast_pin_b_oe_out <= 1'b0;
        end else begin
            // Kills stay until software drops the matching enable.
            if (fail) begin
                ext_kill_q <= 1'b1; // RULE_11
                if (ext_in_use) begin
                    use_int_q <= 1'b1; // RULE_14
                end
                if ((system_clock_sel_out == `RCB_SRC_PLL) && pll_from_ext_in) begin
                    pll_kill_q <= 1'b1; // RULE_15
                end
            end else begin
                if (!fast_ext_on_in) ext_kill_q <= 1'b0;
                if (!pll_on_in) pll_kill_q <= 1'b0;
                if (system_clock_sel_in == `RCB_SRC_FAST_INT) use_int_q <= 1'b0;
            end
            fast_int_en_out <= fast_int_on_in | use_int_q | fail |
                (system_clock_sel_out == `RCB_SRC_FAST_INT); // RULE_07
            fast_ext_en_out <= fast_ext_on_in & ~ext_kill_q & ~fail; // RULE_07 RULE_11
            pll_en_out <= pll_on_in & ~pll_kill_q &
                ~(fail & (system_clock_sel_out == `RCB_SRC_PLL) & pll_from_ext_in);
            slow_int_en_out <= slow_int_on_in | independent_watchdog_in; // RULE_05
            slow_ext_en_out <= slow_ext_on_in; // RULE_06
            if (fail && ext_in_use) begin
                system_clock_sel_out <= `RCB_SRC_FAST_INT; // RULE_14
            end else if (use_int_q) begin
                system_clock_sel_out <= `RCB_SRC_FAST_INT;
            end else if (system_clock_sel_in == `RCB_SRC_FAST_EXT || system_clock_sel_in == `RCB_SRC_PLL) begin
                system_clock_sel_out <= system_clock_sel_in; // RULE_04
            end else begin
                system_clock_sel_out <= `RCB_SRC_FAST_INT;
            end
            if (rtc_sel_in == `RCB_RTC_SLOW_INT || rtc_sel_in == `RCB_RTC_SLOW_EXT) begin
                rtc_clock_sel_out <= rtc_sel_in; // RULE_05 RULE_06
            end else begin
                rtc_clock_sel_out <= `RCB_RTC_NONE;
            end
            // The output pin is driven only in crystal mode.
            fast_pin_b_oe_out <= fast_ext_en_out & ~fast_ext_bypass_in; // RULE_08
            // Detector waits out startup and stops with the oscillator.
            if (!monitor_en_in || !fast_ext_en_out) begin // RULE_09 RULE_10
                start_cnt_q <= 8'h00;
                monitor_active_out <= 1'b0;
            end else if (start_cnt_q != `RCB_FAST_EXT_START_CYC) begin
                start_cnt_q <= start_cnt_q + 8'h01; // RULE_10
            end else begin
                monitor_active_out <= 1'b1;
            end
            if (!monitor_active_out || (tick_s3_q != tick_s2_q)) begin
                idle_cnt_q <= 8'h00;
            end else if (idle_cnt_q != `RCB_FAIL_TIMEOUT) begin
                idle_cnt_q <= idle_cnt_q + 8'h01;
            end
            advanced_timer_break_out <= fail; // RULE_12
            if (fail) begin
                clock_fail_irq_out <= 1'b1; // RULE_13
            end
        end
    end

    // Boot latch at the fourth edge after release or standby exit.
    always @(posedge clk_sys_in) begin
        if (sys_rst || standby_exit_in) begin // RULE_19
            boot_cnt_q <= 3'h0;
            boot_done_out <= 1'b0;
            if (sys_rst) boot_space_out <= `RCB_BOOT_FLASH;
        end else if (!boot_done_out) begin
            boot_cnt_q <= boot_cnt_q + 3'h1;
            if (boot_pulse) begin // RULE_17 RULE_18
                boot_done_out <= 1'b1;
                if (!boot_select_0_s2_q) begin
                    boot_space_out <= `RCB_BOOT_FLASH; // RULE_16
                end else if (!boot_select_1_s2_q) begin
                    boot_space_out <= `RCB_BOOT_SYSMEM; // RULE_16
                end else begin
                    boot_space_out <= `RCB_BOOT_SRAM; // RULE_16
                end
            end
        end
    end
endmodule // rcb_ctrl

// ===== common/rcb_map.vh
// Constants for the reset, clock-fail and boot-select controller.
`ifndef RCB_MAP_VH
`define RCB_MAP_VH
`define RCB_SRC_FAST_INT 2'h0
`define RCB_SRC_FAST_EXT 2'h1
`define RCB_SRC_PLL 2'h2
`define RCB_RTC_NONE 2'h0
`define RCB_RTC_SLOW_INT 2'h1
`define RCB_RTC_SLOW_EXT 2'h2
`define RCB_BOOT_FLASH 2'h0
`define RCB_BOOT_SYSMEM 2'h1
`define RCB_BOOT_SRAM 2'h2
`define RCB_CAUSE_PIN 0
`define RCB_CAUSE_WWD 1
`define RCB_CAUSE_IWD 2
`define RCB_CAUSE_SW 3
`define RCB_CAUSE_LP 4
`define RCB_CAUSE_POR 5
`define RCB_CAUSE_RST 6'h20
`define RCB_RST_HOLD 2'h2
`define RCB_BOOT_EDGE 3'h4
`define RCB_STACK_ADDR 32'h00000000
`define RCB_RESET_VEC_ADDR 32'h00000004
`define RCB_FAST_EXT_START_US 2
`define RCB_CLK_MHZ 10
`define RCB_FAST_EXT_START_CYC (`RCB_FAST_EXT_START_US * `RCB_CLK_MHZ)
`define RCB_FAIL_TIMEOUT 8'h10
`endif

// ===== verification/rcb_checker.sv
// Concurrent checks on the reset, clock-fail and boot-select controller ports.
module rcb_checker (
    input wire clk_sys_in, // System clock.
    input wire rst_n_in, // Power-on reset, active low.
    input wire fast_ext_bypass_in, // Bypass mode.
    input wire pll_from_ext_in, // PLL fed by external osc.
    input wire monitor_en_in, // Monitor enable.
    input wire sys_reset_n_out, // System reset, active low.
    input wire fast_ext_en_out, // External osc run.
    input wire pll_en_out, // PLL run.
    input wire [1:0] system_clock_sel_out, // Active clock source.
    input wire fast_pin_b_oe_out, // Output pin drive.
    input wire monitor_active_out, // Detector running.
    input wire advanced_timer_break_out, // Timer break event.
    input wire clock_fail_irq_out, // Clock-fail request.
    input wire boot_done_out, // Boot latched.
    input wire [31:0] stack_addr_out // Stack address.
);
    default clocking cb @(posedge clk_sys_in); endclocking
    default disable iff (!rst_n_in);
    a_stack_fixed: assert property (stack_addr_out == 32'h0)
        else $error("stack address not zero");
    a_bypass_hiz: assert property (fast_ext_bypass_in [*3] |-> !fast_pin_b_oe_out)
        else $error("output pin driven in bypass");
    a_fail_kills_osc: assert property (advanced_timer_break_out |=> !fast_ext_en_out)
        else $error("external osc still on after fail");
    a_fail_raises_irq: assert property (advanced_timer_break_out |-> ##[0:1] clock_fail_irq_out)
        else $error("fail without interrupt");
    a_fail_switch_int: assert property (advanced_timer_break_out && ($past(system_clock_sel_out) == 2'h1
        || $past(system_clock_sel_out) == 2'h2 && pll_from_ext_in) |=> system_clock_sel_out == 2'h0)
        else $error("system clock not moved to internal");
    a_fail_pll_off: assert property (advanced_timer_break_out && pll_from_ext_in
        && $past(system_clock_sel_out) == 2'h2 |-> ##[0:1] !pll_en_out)
        else $error("PLL left running after fail");
    a_monitor_sw_only: assert property (!monitor_en_in [*2] |-> !monitor_active_out)
        else $error("monitor active while disabled");
    a_monitor_needs_osc: assert property (!fast_ext_en_out [*2] |-> !monitor_active_out)
        else $error("monitor active with osc stopped");
    a_boot_fourth_edge: assert property ($rose(sys_reset_n_out) |-> !boot_done_out ##[2:4] boot_done_out)
        else $error("boot latch timing wrong");
endmodule // rcb_checker
bind rcb_ctrl rcb_checker u_rcb_checker (.clk_sys_in(clk_sys_in), .rst_n_in(rst_n_in),
    .fast_ext_bypass_in(fast_ext_bypass_in), .pll_from_ext_in(pll_from_ext_in),
    .monitor_en_in(monitor_en_in), .sys_reset_n_out(sys_reset_n_out),
    .fast_ext_en_out(fast_ext_en_out), .pll_en_out(pll_en_out),
    .system_clock_sel_out(system_clock_sel_out), .fast_pin_b_oe_out(fast_pin_b_oe_out),
    .monitor_active_out(monitor_active_out), .advanced_timer_break_out(advanced_timer_break_out),
    .clock_fail_irq_out(clock_fail_irq_out), .boot_done_out(boot_done_out),
    .stack_addr_out(stack_addr_out));

// ===== verification/rcb_board.sv
// Board model: reset pin with pull-up, static boot straps and external crystal activity.
module rcb_board (
    input wire clk_sys_in, // System clock.
    input wire pin_low_in, // Press the reset pin.
    input wire [1:0] boot_cfg_in, // Wanted straps, bit 0 is boot pin 0.
    input wire osc_run_in, // Crystal oscillating.
    output wire ext_reset_pin_n_out, // Reset pin level.
    output wire boot_select_0_out, // Boot pin 0.
    output wire boot_select_1_out, // Boot pin 1.
    output logic fast_ext_tick_out // Crystal activity.
);
    timeunit 1ns;
    timeprecision 1ns;
    assign ext_reset_pin_n_out = !pin_low_in;
    assign boot_select_0_out = boot_cfg_in[0];
    assign boot_select_1_out = boot_cfg_in[1];
    initial fast_ext_tick_out = 1'b0;
    // A dead crystal freezes the line rather than floating it.
    always @(posedge clk_sys_in) if (osc_run_in) #30 fast_ext_tick_out <= ~fast_ext_tick_out;
endmodule // rcb_board

// ===== verification/tb.sv
// Self-checking bench for the reset, clock-fail and boot-select controller.
module tb;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk_sys_in = 0, rst_n_in = 0, pin_low = 0, osc_run = 1, wwd = 0, iwd = 0, swr = 0;
    logic lpr = 0, clr = 0, fio = 1, feo = 0, byp = 0, pllo = 0, pfe = 0, sio = 0, seo = 0;
    logic mon = 0, sbx = 0, sup = 1;
    logic [1:0] ssel = 0, rsel = 0, boot = 0;
    wire pin_n, b0, b1, tick, srst_n, oe, fie, fee, ple, sie, see, mact, brk, irq, bdone;
    wire [5:0] causes;
    wire [1:0] csel, rtc, bspace;
    wire [31:0] stk, vec;
    int bad_count = 0, n_compared = 0;
    always #50 clk_sys_in = ~clk_sys_in;
    rcb_board u_rcb_board (.clk_sys_in(clk_sys_in), .pin_low_in(pin_low), .boot_cfg_in(boot),
        .osc_run_in(osc_run), .ext_reset_pin_n_out(pin_n), .boot_select_0_out(b0),
        .boot_select_1_out(b1), .fast_ext_tick_out(tick));
    rcb_ctrl u_rcb_ctrl (.clk_sys_in(clk_sys_in), .rst_n_in(rst_n_in), .supply_ok_in(sup),
        .ext_reset_pin_n_in(pin_n), .window_watchdog_in(wwd), .independent_watchdog_in(iwd),
        .sw_reset_req_in(swr), .lp_reset_req_in(lpr), .clear_causes_in(clr), .fast_int_on_in(fio),
        .fast_ext_on_in(feo), .fast_ext_bypass_in(byp), .pll_on_in(pllo), .pll_from_ext_in(pfe),
        .slow_int_on_in(sio), .slow_ext_on_in(seo), .system_clock_sel_in(ssel), .rtc_sel_in(rsel),
        .monitor_en_in(mon), .fast_ext_tick_in(tick), .standby_exit_in(sbx),
        .boot_select_0_in(b0), .boot_select_1_in(b1), .sys_reset_n_out(srst_n),
        .clock_ctrl_status_reg_out(causes), .fast_int_en_out(fie), .fast_ext_en_out(fee),
        .pll_en_out(ple), .slow_int_en_out(sie), .slow_ext_en_out(see),
        .system_clock_sel_out(csel), .rtc_clock_sel_out(rtc), .fast_pin_b_oe_out(oe),
        .monitor_active_out(mact), .advanced_timer_break_out(brk), .clock_fail_irq_out(irq),
        .boot_space_out(bspace), .boot_done_out(bdone), .stack_addr_out(stk),
        .reset_vec_addr_out(vec));
    task automatic step(input int n);
        repeat (n) @(posedge clk_sys_in);
        #1;
    endtask
    task automatic test_done;
        $display("compared %0d, mismatches %0d", n_compared, bad_count);
        if (bad_count == 0 && n_compared > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            bad_count++;
            $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic wait_boot;
        int i;
        for (i = 0; i < 10 && srst_n !== 1'b0; i++) step(1);
        for (i = 0; i < 60 && !(srst_n === 1'b1 && bdone === 1'b1); i++) step(1);
        if (srst_n !== 1'b1 || bdone !== 1'b1) begin
            bad_count++;
            $display("MISMATCH at %0t: boot not reached", $time);
            test_done;
        end
    endtask
    task automatic t_boot;
        for (int k = 0; k < 4; k++) begin
            boot = k[1:0]; swr = 1; step(1); swr = 0; wait_boot;
            chk(32'(bspace), boot[0] ? 32'(boot[1]) + 32'h1 : 32'h0);
        end
        boot = 2'h1; sbx = 1; step(1); sbx = 0; step(8);
        chk(32'(bspace), 32'h1);
        chk(vec, 32'h4);
        $display("t_boot done");
    endtask
    task automatic t_causes;
        logic [5:0] exp;
        clr = 1; step(1); clr = 0; step(1);
        chk(32'(causes), 32'h0);
        exp = 6'h0;
        for (int k = 0; k < 5; k++) begin
            {lpr, swr, iwd, wwd, pin_low} = 5'h1 << k; step(3); {lpr, swr, iwd, wwd, pin_low} = 0;
            wait_boot; exp[k] = 1'b1;
            chk(32'(causes), 32'(exp));
        end
        $display("t_causes done");
    endtask
    task automatic t_clocks;
        for (int k = 0; k < 32; k += 5) begin
            {fio, feo, pllo, sio, seo} = k[4:0]; step(2);
            // The internal oscillator stays on while it clocks the system.
            chk(32'({fie, fee, ple, sie, see}), 32'(k[4:0] | 5'h10));
        end
        for (int k = 0; k < 4; k++) begin
            ssel = k[1:0]; rsel = k[1:0]; step(2);
            chk(32'({csel, rtc}), k == 3 ? 32'h0 : 32'(k * 5));
        end
        fio = 1; feo = 1; step(3); chk(32'(oe), 32'h1);
        byp = 1; step(3); chk(32'(oe), 32'h0);
        byp = 0; ssel = 0; feo = 0;
        $display("t_clocks done");
    endtask
    task automatic t_fail;
        int i;
        pllo = 1; pfe = 1; ssel = 2'h2; mon = 1; step(3);
        chk(32'(mact), 32'h0);
        feo = 1; step(12); chk(32'(mact), 32'h0);
        step(30); chk(32'({mact, irq, csel}), 32'ha);
        osc_run = 0;
        for (i = 0; i < 40 && irq !== 1'b1; i++) step(1);
        step(1); chk(32'({fee, ple, csel, irq}), 32'h1);
        osc_run = 1; mon = 0; pfe = 0; pllo = 0; feo = 0; ssel = 0;
        swr = 1; step(1); swr = 0; wait_boot;
        chk(32'(irq), 32'h0);
        $display("t_fail done");
    endtask
    task automatic t_supply;
        sup = 0; step(2);
        chk(32'(srst_n), 32'h0);
        sup = 1; wait_boot;
        chk(32'(causes), 32'h20);
        $display("t_supply done");
    endtask
    initial begin
        step(10); rst_n_in = 1; wait_boot;
        chk(32'(causes), 32'h20);
        t_boot; t_causes; t_clocks; t_fail; t_supply;
        test_done;
    end
endmodule // tb
